// ---- bpu_defs.vh ----
// Shared constants of the branch prediction unit
`ifndef BPU_DEFS_VH
`define BPU_DEFS_VH

// History table: 8192 two-bit counters, 13-bit index
`define BPU_PHT_DEPTH 8192
`define BPU_PHT_AW 13
`define BPU_CTR_INIT 2'h1
`define BPU_CTR_MAX 2'h3
`define BPU_CTR_MIN 2'h0

// Target cache: 16 entries of 16 bytes
`define BPU_BTC_DEPTH 16
`define BPU_BTC_IW 4
`define BPU_BTC_TW 24
`define BPU_LINE_BITS 128
`define BPU_LINE_BYTES 32'h00000010

// Return stack depth
`define BPU_RAS_DEPTH 16
`define BPU_RAS_AW 4

// Outstanding branch limit, slot ring of eight positions
`define BPU_MAX_BR 4'h7
`define BPU_SLOT_AW 3
`define BPU_SLOTS 8

// Branch kinds from the decoder
`define BPU_K_NONE 3'h0
`define BPU_K_JMP 3'h1
`define BPU_K_JCC 3'h2
`define BPU_K_CALL 3'h3
`define BPU_K_RET 3'h4
`define BPU_K_LOOP 3'h5

// Target candidate select
`define BPU_T_REL8 2'h0
`define BPU_T_REL32 2'h1
`define BPU_T_ABS 2'h2
`define BPU_T_SEQ 2'h3

`endif

// ---- bpu_monitor.sv ----
// Concurrent checks on the branch prediction unit top ports
`timescale 1ns/10ps
// ****************************************
// Checker
// ****************************************
module bpu_monitor (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire dec_valid_i,
  input wire [2:0] dec_kind_i,
  input wire res_valid_i,
  input wire res_taken_i,
  input wire dec_ready_o,
  input wire fetch_redirect_o,
  input wire ibuf_flush_o,
  input wire ibuf_fill_o,
  input wire ret_nopred_o,
  input wire alloc_o,
  input wire spec_pending_o,
  input wire [2:0] spec_oldest_o,
  input wire res_done_o,
  input wire res_actual_o,
  input wire res_mispredict_o,
  input wire [2:0] restore_id_o
);
  reg [3:0] n_open;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Open branch count; a misprediction empties the whole ring
  always @(posedge ref_clk_i) begin
    if (sys_rst_i || res_mispredict_o) begin
      n_open <= 4'h0;
    end else begin
      n_open <= n_open + {3'h0, alloc_o} - {3'h0, res_done_o};
    end
  end
  sequence jmp_take;
    dec_valid_i && dec_ready_o && dec_kind_i == 3'h1;
  endsequence
  sequence cond_take;
    dec_valid_i && dec_ready_o && (dec_kind_i == 3'h2 || dec_kind_i == 3'h5);
  endsequence
  // A misprediction near the take may drop the younger branch
  sequence quiet2;
    ##1 !res_mispredict_o ##1 !res_mispredict_o;
  endsequence
  AST_JMP_REDIRECT: assert property (jmp_take ##1 !res_mispredict_o |-> ##1 fetch_redirect_o)
    else $error("jump did not redirect two cycles later");
  AST_JMP_NO_ALLOC: assert property (jmp_take |-> ##2 !alloc_o)
    else $error("jump took a predictor slot");
  AST_COND_ALLOC: assert property (cond_take ##0 quiet2 |-> alloc_o)
    else $error("conditional branch got no slot");
  AST_FLUSH_ON_REDIRECT: assert property (fetch_redirect_o |-> ibuf_flush_o)
    else $error("redirect without buffer flush");
  AST_FILL_ON_REDIRECT: assert property (ibuf_fill_o |-> fetch_redirect_o)
    else $error("buffer fill outside a redirect");
  AST_OPEN_LIMIT: assert property (n_open <= 4'h7)
    else $error("more than seven open branches");
  AST_STALL_AT_LIMIT: assert property (n_open == 4'h7 && !res_done_o |-> !dec_ready_o)
    else $error("decode ready with seven open branches");
  AST_RESOLVE_ANSWER: assert property (res_valid_i && spec_pending_o |=>
      res_done_o && res_actual_o == $past(res_taken_i))
    else $error("resolve answer missing or wrong");
  AST_MISPRED_RECOVER: assert property (res_mispredict_o |-> res_done_o && fetch_redirect_o
      && !spec_pending_o && restore_id_o == $past(spec_oldest_o))
    else $error("misprediction recovery incomplete");
  AST_NOPRED_QUIET: assert property (ret_nopred_o |-> !fetch_redirect_o || res_mispredict_o)
    else $error("unpredicted return redirected fetch");
  AST_PENDING_HOLDS: assert property (alloc_o && !res_mispredict_o ##1 !res_done_o
      |-> spec_pending_o)
    else $error("open branch not shown as pending");
endmodule // bpu_monitor

bind branch_prediction_unit bpu_monitor u_mon (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
  .dec_valid_i(dec_valid_i), .dec_kind_i(dec_kind_i), .res_valid_i(res_valid_i),
  .res_taken_i(res_taken_i), .dec_ready_o(dec_ready_o), .fetch_redirect_o(fetch_redirect_o),
  .ibuf_flush_o(ibuf_flush_o), .ibuf_fill_o(ibuf_fill_o), .ret_nopred_o(ret_nopred_o),
  .alloc_o(alloc_o), .spec_pending_o(spec_pending_o), .spec_oldest_o(spec_oldest_o),
  .res_done_o(res_done_o), .res_actual_o(res_actual_o), .res_mispredict_o(res_mispredict_o),
  .restore_id_o(restore_id_o));

// ---- branch_prediction_unit.v ----
// Branch prediction, target cache, return stack and speculation control
// Function
// - Unconditional branches redirect fetch, predictor unused.
// - Two-level adaptive prediction, 8192-entry history table.
// - No stored targets; decode adders compute them.
// - All candidate targets computed in parallel.
// - Target cache hit feeds 16 bytes to buffer.
// - Target cache holds 16 entries of 16 bytes.
// - 16-entry return stack pushes address after call.
// - Return pops stack top and fetches there.
// - Not-taken branch continues with sequential instructions.
// - No commit past unresolved speculative branches.
// - Misprediction discards younger work, restores registers.
// - At most seven unresolved branches; then stall.
// - Condition unit resolves, reports actual outcome.
// - Every redirect flushes buffer; only a target cache hit refills it.
`timescale 1ns/10ps
`include "bpu_defs.vh"

module branch_prediction_unit (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire dec_valid_i,
  input wire [2:0] dec_kind_i,
  input wire [31:0] dec_pc_i,
  input wire [3:0] dec_len_i,
  input wire [7:0] dec_disp8_i,
  input wire [31:0] dec_disp32_i,
  input wire [1:0] dec_tsel_i,
  input wire res_valid_i,
  input wire res_taken_i,
  input wire btc_wr_i,
  input wire [31:0] btc_wr_addr_i,
  input wire [`BPU_LINE_BITS-1:0] btc_wr_data_i,
  output reg dec_ready_o,
  output reg fetch_redirect_o,
  output reg [31:0] fetch_addr_o,
  output reg ibuf_flush_o,
  output reg ibuf_fill_o,
  output reg [`BPU_LINE_BITS-1:0] ibuf_data_o,
  output reg ret_nopred_o,
  output reg alloc_o,
  output reg [2:0] alloc_id_o,
  output reg alloc_pred_o,
  output reg spec_pending_o,
  output reg [2:0] spec_oldest_o,
  output reg res_done_o,
  output reg res_actual_o,
  output reg res_mispredict_o,
  output reg [2:0] restore_id_o
);

  // ************************************************************
  // Helpers
  // ************************************************************
  // Saturating two-bit counter step
  function [1:0] ctr_step;
    input [1:0] ctr;
    input taken;
    begin
      if (taken) begin
        ctr_step = (ctr == `BPU_CTR_MAX) ? ctr : ctr + 2'h1;
      end else begin
        ctr_step = (ctr == `BPU_CTR_MIN) ? ctr : ctr - 2'h1;
      end
    end
  endfunction

  // Conditional kinds go through the dynamic predictor
  function is_cond;
    input [2:0] kind;
    begin
      is_cond = (kind == `BPU_K_JCC) || (kind == `BPU_K_LOOP);
    end
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  reg [`BPU_PHT_AW-1:0] ghr;
  reg [`BPU_RAS_AW-1:0] ras_top;
  reg [4:0] ras_cnt;
  reg [31:0] ras_mem [0:`BPU_RAS_DEPTH-1];
  reg [`BPU_SLOT_AW-1:0] head;
  reg [`BPU_SLOT_AW-1:0] tail;
  reg [3:0] count;
  reg slot_pred [0:`BPU_SLOTS-1];
  reg [31:0] slot_alt [0:`BPU_SLOTS-1];
  reg [`BPU_PHT_AW-1:0] slot_idx [0:`BPU_SLOTS-1];
  reg [1:0] slot_ctr [0:`BPU_SLOTS-1];
  reg [`BPU_PHT_AW-1:0] slot_ghr [0:`BPU_SLOTS-1];
  // Stage A: decoded branch waiting for the memory reads
  reg a_valid;
  reg [2:0] a_kind;
  reg [31:0] a_seq;
  reg [31:0] a_target;
  reg [`BPU_PHT_AW-1:0] a_idx;
  reg [31:0] a_ras_val;
  reg a_ras_ok;

  wire [1:0] pht_rd;
  wire pht_busy;
  wire btc_valid;
  wire [`BPU_BTC_TW-1:0] btc_tag;
  wire [`BPU_LINE_BITS-1:0] btc_data;

  // ************************************************************
  // Decode-stage target adders
  // ************************************************************
  wire dec_fire = dec_valid_i && dec_ready_o;
  wire [31:0] t_seq = dec_pc_i + {28'h0000000, dec_len_i};
  wire [31:0] t_rel8 = t_seq + {{24{dec_disp8_i[7]}}, dec_disp8_i};
  wire [31:0] t_rel32 = t_seq + dec_disp32_i;
  // targets come from adders, not the table
  reg [31:0] dec_target;
  always @* begin
    case (dec_tsel_i)
      `BPU_T_REL8: dec_target = t_rel8;
      `BPU_T_REL32: dec_target = t_rel32;
      `BPU_T_ABS: dec_target = dec_disp32_i;
      default: dec_target = t_seq;
    endcase
  end

  // two-level index: address folded with global history
  wire [`BPU_PHT_AW-1:0] dec_idx = dec_pc_i[`BPU_PHT_AW-1:0] ^ ghr;
  wire [`BPU_RAS_AW-1:0] ras_below = ras_top - 1'b1;

  // ************************************************************
  // Memories
  // ************************************************************
  wire res_mis = res_valid_i && (count != 4'h0) && (res_taken_i != slot_pred[head]);
  wire res_go = res_valid_i && (count != 4'h0);

  // history table trained with executed outcomes
  pht_mem u_pht (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .rd_addr_i(dec_idx),
    .rd_data_o(pht_rd),
    .wr_en_i(res_go),
    .wr_addr_i(slot_idx[head]),
    .wr_data_i(ctr_step(slot_ctr[head], res_taken_i)),
    .busy_o(pht_busy)
  );

  // sixteen lines of sixteen bytes; a return looks up its stacked address
  btc_mem u_btc (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .rd_idx_i(dec_kind_i == `BPU_K_RET ? ras_mem[ras_below][7:4] : dec_target[7:4]),
    .rd_valid_o(btc_valid),
    .rd_tag_o(btc_tag),
    .rd_data_o(btc_data),
    .wr_en_i(btc_wr_i),
    .wr_idx_i(btc_wr_addr_i[7:4]),
    .wr_tag_i(btc_wr_addr_i[31:8]),
    .wr_data_i(btc_wr_data_i)
  );

  // ************************************************************
  // Stage B: prediction and redirect
  // ************************************************************
  reg b_taken;
  reg b_alloc;
  reg b_hit;
  reg b_nopred;
  reg [31:0] b_dest;
  always @* begin
    b_taken = 1'b0;
    b_alloc = 1'b0;
    b_nopred = 1'b0;
    b_dest = a_target;
    case (a_kind)
      `BPU_K_JMP, `BPU_K_CALL: b_taken = 1'b1;
      `BPU_K_JCC, `BPU_K_LOOP: begin
        b_taken = pht_rd[1];
        b_alloc = 1'b1;
      end
      `BPU_K_RET: begin
        b_taken = a_ras_ok;
        b_nopred = !a_ras_ok;
        b_dest = a_ras_val;
      end
      default: b_taken = 1'b0;
    endcase
    // cached line only for a predicted-taken target
    b_hit = b_taken && btc_valid && (btc_tag == b_dest[31:8]) && (b_dest[3:0] == 4'h0);
  end

  // A misprediction kills the younger branch in stage A
  wire b_live = a_valid && !res_mis;
  wire do_alloc = b_live && b_alloc;
  wire [3:0] next_count = res_mis ? 4'h0 :
                          count + {3'h0, do_alloc} - {3'h0, res_go};
  wire next_a_cond = dec_fire && !res_mis && is_cond(dec_kind_i);

  // ************************************************************
  // Sequential state
  // ************************************************************
  // Slot ring, history and resolution
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      head <= {`BPU_SLOT_AW{1'b0}};
      tail <= {`BPU_SLOT_AW{1'b0}};
      count <= 4'h0;
      ghr <= {`BPU_PHT_AW{1'b0}};
    end else begin
      count <= next_count;
      if (res_mis) begin
        head <= head + 1'b1;
        tail <= head + 1'b1;
        ghr <= {slot_ghr[head][`BPU_PHT_AW-2:0], res_taken_i};
      end else begin
        head <= head + {2'h0, res_go};
        if (do_alloc) begin
          tail <= tail + 1'b1;
          ghr <= {ghr[`BPU_PHT_AW-2:0], b_taken};
        end
      end
    end
  end

  // Slot payload; the alternate address is the recovery fetch point
  always @(posedge ref_clk_i) begin
    if (do_alloc) begin
      slot_pred[tail] <= b_taken;
      slot_alt[tail] <= b_taken ? a_seq : a_target;
      slot_idx[tail] <= a_idx;
      slot_ctr[tail] <= pht_rd;
      slot_ghr[tail] <= ghr;
    end
  end

  // Stage A capture
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      a_valid <= 1'b0;
      a_kind <= `BPU_K_NONE;
    end else begin
      a_valid <= dec_fire && !res_mis;
      a_kind <= dec_kind_i;
    end
    a_seq <= t_seq;
    a_target <= dec_target;
    a_idx <= dec_idx;
    a_ras_val <= ras_mem[ras_below];
    a_ras_ok <= (ras_cnt != 5'h00);
  end

  // Return stack is not repaired on recovery; a wrong entry only mispredicts
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ras_top <= {`BPU_RAS_AW{1'b0}};
      ras_cnt <= 5'h00;
    end else if (dec_fire && !res_mis) begin
      if (dec_kind_i == `BPU_K_CALL) begin
        // push the address after the call
        ras_mem[ras_top] <= t_seq;
        ras_top <= ras_top + 1'b1;
        if (ras_cnt != 5'h10) begin
          ras_cnt <= ras_cnt + 5'h01;
        end
      end else if (dec_kind_i == `BPU_K_RET && ras_cnt != 5'h00) begin
        ras_top <= ras_below;
        ras_cnt <= ras_cnt - 5'h01;
      end
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  // Fetch, buffer and report outputs
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      dec_ready_o <= 1'b0;
      fetch_redirect_o <= 1'b0;
      fetch_addr_o <= 32'h00000000;
      ibuf_flush_o <= 1'b0;
      ibuf_fill_o <= 1'b0;
      ibuf_data_o <= {`BPU_LINE_BITS{1'b0}};
      ret_nopred_o <= 1'b0;
      alloc_o <= 1'b0;
      alloc_id_o <= 3'h0;
      alloc_pred_o <= 1'b0;
      spec_pending_o <= 1'b0;
      spec_oldest_o <= 3'h0;
      res_done_o <= 1'b0;
      res_actual_o <= 1'b0;
      res_mispredict_o <= 1'b0;
      restore_id_o <= 3'h0;
    end else begin
      // stall once seven branches are in flight
      dec_ready_o <= !pht_busy && (next_count + {3'h0, next_a_cond} < `BPU_MAX_BR);
      // report the actual outcome and the comparison
      res_done_o <= res_go;
      res_actual_o <= res_taken_i;
      res_mispredict_o <= res_mis;
      restore_id_o <= head;
      // scheduler holds commits at the oldest open branch
      spec_pending_o <= (next_count != 4'h0);
      spec_oldest_o <= res_mis ? head + 1'b1 : (res_go ? head + 1'b1 : head);
      alloc_o <= do_alloc;
      alloc_id_o <= tail;
      alloc_pred_o <= b_taken;
      ret_nopred_o <= b_live && b_nopred;
      ibuf_fill_o <= 1'b0;
      // not taken: sequential fetch carries on
      fetch_redirect_o <= 1'b0;
      ibuf_flush_o <= 1'b0;
      if (res_mis) begin
        // recovery fetch from the other path
        // flush and fetch from the new address; no cached fill
        fetch_redirect_o <= 1'b1;
        ibuf_flush_o <= 1'b1;
        fetch_addr_o <= slot_alt[head];
      end else if (b_live && b_taken) begin
        fetch_redirect_o <= 1'b1;
        ibuf_flush_o <= 1'b1;
        // cached bytes go in; fetch resumes past them
        ibuf_fill_o <= b_hit;
        ibuf_data_o <= btc_data;
        fetch_addr_o <= b_hit ? b_dest + `BPU_LINE_BYTES : b_dest;
      end
    end
  end

endmodule // branch_prediction_unit

// ---- btc_mem.v ----
// Branch target cache storage: tag, valid and 16 bytes per entry
`timescale 1ns/10ps
`include "bpu_defs.vh"

module btc_mem (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire [`BPU_BTC_IW-1:0] rd_idx_i,
  output reg rd_valid_o,
  output reg [`BPU_BTC_TW-1:0] rd_tag_o,
  output reg [`BPU_LINE_BITS-1:0] rd_data_o,
  input wire wr_en_i,
  input wire [`BPU_BTC_IW-1:0] wr_idx_i,
  input wire [`BPU_BTC_TW-1:0] wr_tag_i,
  input wire [`BPU_LINE_BITS-1:0] wr_data_i
);

  reg [`BPU_LINE_BITS-1:0] data_mem [0:`BPU_BTC_DEPTH-1];
  reg [`BPU_BTC_TW-1:0] tag_mem [0:`BPU_BTC_DEPTH-1];
  reg [`BPU_BTC_DEPTH-1:0] valid;

  // Arrays carry no reset; the valid bits guard them
  always @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      data_mem[wr_idx_i] <= wr_data_i;
      tag_mem[wr_idx_i] <= wr_tag_i;
    end
    rd_data_o <= data_mem[rd_idx_i];
    rd_tag_o <= tag_mem[rd_idx_i];
  end

  // Valid bits, cleared at reset
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      valid <= {`BPU_BTC_DEPTH{1'b0}};
      rd_valid_o <= 1'b0;
    end else begin
      if (wr_en_i) begin
        valid[wr_idx_i] <= 1'b1;
      end
      rd_valid_o <= valid[rd_idx_i];
    end
  end

endmodule // btc_mem

// ---- cond_unit_model.sv ----
// Condition unit stand-in: resolves the oldest open branch on command
`timescale 1ns/10ps
// ****************************************
// Resolver model
// ****************************************
module cond_unit_model (
  input wire ref_clk_i,
  output reg res_valid_o,
  output reg res_taken_o
);
  initial begin
    res_valid_o = 1'b0;
    res_taken_o = 1'b0;
  end
  // Slow answers wait dly cycles; released outcome line shows the inverse
  task resolve(input int dly, input logic taken);
    begin
      repeat (dly) @(negedge ref_clk_i);
      res_valid_o = 1'b1;
      res_taken_o = taken;
      @(negedge ref_clk_i);
      res_valid_o = 1'b0;
      res_taken_o = ~taken;
    end
  endtask
endmodule // cond_unit_model

// ---- pht_mem.v ----
// Branch history counter memory with registered read and reset sweep
`timescale 1ns/10ps
`include "bpu_defs.vh"

module pht_mem (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire [`BPU_PHT_AW-1:0] rd_addr_i,
  output reg [1:0] rd_data_o,
  input wire wr_en_i,
  input wire [`BPU_PHT_AW-1:0] wr_addr_i,
  input wire [1:0] wr_data_i,
  output reg busy_o
);

  reg [1:0] mem [0:`BPU_PHT_DEPTH-1];
  reg [`BPU_PHT_AW-1:0] clr_addr;

  // Sweep writes the initial counter value; updates during it are dropped
  always @(posedge ref_clk_i) begin
    if (busy_o) begin
      mem[clr_addr] <= `BPU_CTR_INIT;
    end else if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

  // Sweep control
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      busy_o <= 1'b1;
      clr_addr <= {`BPU_PHT_AW{1'b0}};
    end else if (busy_o) begin
      clr_addr <= clr_addr + 1'b1;
      if (&clr_addr) begin
        busy_o <= 1'b0;
      end
    end
  end

endmodule // pht_mem

// ---- tb_top.sv ----
// Self-checking bench for the branch prediction unit
`timescale 1ns/10ps
`include "bpu_defs.vh"
module tb_top;
  logic ref_clk_i, sys_rst_i, dec_valid_i, res_valid_i, res_taken_i, btc_wr_i;
  logic [2:0] dec_kind_i;
  logic [31:0] dec_pc_i, dec_disp32_i, btc_wr_addr_i, fetch_addr_o;
  logic [3:0] dec_len_i;
  logic [7:0] dec_disp8_i;
  logic [1:0] dec_tsel_i;
  logic [127:0] btc_wr_data_i, ibuf_data_o;
  logic dec_ready_o, fetch_redirect_o, ibuf_flush_o, ibuf_fill_o, ret_nopred_o, alloc_o;
  logic alloc_pred_o, spec_pending_o, res_done_o, res_actual_o, res_mispredict_o;
  logic [2:0] alloc_id_o, spec_oldest_o, restore_id_o, id0;
  int n_fail, samples_checked, n;
  branch_prediction_unit u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .dec_valid_i(dec_valid_i), .dec_kind_i(dec_kind_i), .dec_pc_i(dec_pc_i),
    .dec_len_i(dec_len_i), .dec_disp8_i(dec_disp8_i), .dec_disp32_i(dec_disp32_i),
    .dec_tsel_i(dec_tsel_i), .res_valid_i(res_valid_i), .res_taken_i(res_taken_i),
    .btc_wr_i(btc_wr_i), .btc_wr_addr_i(btc_wr_addr_i), .btc_wr_data_i(btc_wr_data_i),
    .dec_ready_o(dec_ready_o), .fetch_redirect_o(fetch_redirect_o), .fetch_addr_o(fetch_addr_o),
    .ibuf_flush_o(ibuf_flush_o), .ibuf_fill_o(ibuf_fill_o), .ibuf_data_o(ibuf_data_o),
    .ret_nopred_o(ret_nopred_o), .alloc_o(alloc_o), .alloc_id_o(alloc_id_o),
    .alloc_pred_o(alloc_pred_o), .spec_pending_o(spec_pending_o),
    .spec_oldest_o(spec_oldest_o), .res_done_o(res_done_o), .res_actual_o(res_actual_o),
    .res_mispredict_o(res_mispredict_o), .restore_id_o(restore_id_o));
  cond_unit_model u_cond (.ref_clk_i(ref_clk_i), .res_valid_o(res_valid_i),
    .res_taken_o(res_taken_i));
  // ****************************************
  // Clock, checks and bus tasks
  // ****************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task stop_test;
    begin
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input logic ok, input string m);
    begin
      samples_checked++;
      if (ok !== 1'b1) begin
        n_fail++;
        $display("mismatch at %0t: %s", $time, m);
      end
    end
  endtask
  // Offer one branch, hold until taken, return after the take edge
  task dec(input logic [2:0] k, input logic [31:0] pc, input logic [3:0] ln,
      input logic [7:0] d8, input logic [31:0] d32, input logic [1:0] ts);
    int w;
    begin
      w = 0;
      @(negedge ref_clk_i);
      {dec_kind_i, dec_pc_i, dec_len_i, dec_disp8_i, dec_disp32_i, dec_tsel_i} = {k, pc, ln, d8, d32, ts};
      dec_valid_i = 1'b1;
      while (dec_ready_o !== 1'b1 && w < 50) begin
        @(negedge ref_clk_i);
        w++;
      end
      chk(w < 50, "decode never accepted");
      @(negedge ref_clk_i);
      dec_valid_i = 1'b0;
      @(negedge ref_clk_i);
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_jmp;
    logic [31:0] e [4];
    begin
      e = '{32'h00000400, 32'h00000432, 32'h00000030, 32'h00000402};
      for (int i = 0; i < 4; i++) begin
        dec(`BPU_K_JMP, 32'h00000400, 4'h2, 8'hfe, 32'h00000030, i[1:0]);
        chk(fetch_redirect_o === 1'b1 && ibuf_flush_o === 1'b1, "jump flush");
        chk(fetch_addr_o === e[i] && alloc_o === 1'b0, "jump target");
      end
    end
  endtask
  // Lines at index 3 and 15; a tag miss on index 3 must not fill
  task t_btc;
    logic [31:0] a [2];
    begin
      a = '{32'h00001230, 32'h000034f0};
      for (int i = 0; i < 2; i++) begin
        @(negedge ref_clk_i);
        {btc_wr_i, btc_wr_addr_i, btc_wr_data_i} = {1'b1, a[i], {4{a[i]}}};
        @(negedge ref_clk_i);
        btc_wr_i = 1'b0;
        dec(`BPU_K_JMP, 32'h00000500, 4'h2, 8'h00, a[i], `BPU_T_ABS);
        chk(ibuf_fill_o === 1'b1 && ibuf_data_o === {4{a[i]}}, "cached line");
        chk(fetch_addr_o === a[i] + 32'h00000010, "fetch past cached line");
      end
      dec(`BPU_K_JMP, 32'h00000500, 4'h2, 8'h00, 32'h00002230, `BPU_T_ABS);
      chk(ibuf_fill_o === 1'b0 && fetch_addr_o === 32'h00002230, "tag miss");
    end
  endtask
  // Seventeen calls overwrite the oldest; the seventeenth return is unpredicted
  task t_ras;
    begin
      for (int i = 0; i < 17; i++) begin
        dec(`BPU_K_CALL, 32'h00008000 + i * 16, 4'h3, 8'h00, 32'h00009000, `BPU_T_ABS);
        chk(fetch_redirect_o === 1'b1 && fetch_addr_o === 32'h00009000, "call target");
      end
      for (int j = 0; j < 17; j++) begin
        dec(`BPU_K_RET, 32'h00009100, 4'h1, 8'h00, 32'h00000000, `BPU_T_SEQ);
        if (j < 16) chk(fetch_addr_o === 32'h00008003 + (16 - j) * 16, "return addr");
        else chk(ret_nopred_o === 1'b1 && fetch_redirect_o === 1'b0, "empty return");
      end
    end
  endtask
  task t_spec;
    begin
      for (int k = 0; k < 7; k++) begin
        dec(k == 3 ? `BPU_K_LOOP : `BPU_K_JCC, 32'h00000600 + k * 16, 4'h2, 8'h10,
            32'h00000000, `BPU_T_REL8);
        if (k == 0) id0 = alloc_id_o;
        chk(alloc_o === 1'b1 && alloc_pred_o === 1'b0 && fetch_redirect_o === 1'b0, "alloc");
        chk(alloc_id_o === id0 + k[2:0], "slot order");
      end
      chk(dec_ready_o === 1'b0 && spec_pending_o === 1'b1, "stall at seven");
      chk(spec_oldest_o === id0, "oldest slot");
      u_cond.resolve(0, 1'b0);
      chk(spec_oldest_o === id0 + 3'h1, "oldest advances");
      chk(res_done_o === 1'b1 && res_mispredict_o === 1'b0 && res_actual_o === 1'b0, "nt");
      chk(fetch_redirect_o === 1'b0, "not taken stays sequential");
      u_cond.resolve(3, 1'b1);
      chk(res_mispredict_o === 1'b1 && restore_id_o === id0 + 3'h1, "restore slot");
      chk(fetch_addr_o === 32'h00000622 && spec_pending_o === 1'b0, "recovery path");
      chk(fetch_redirect_o === 1'b1 && ibuf_flush_o === 1'b1, "recovery flush");
      n = 0;
      while (dec_ready_o !== 1'b1 && n < 10) begin
        @(negedge ref_clk_i);
        n++;
      end
      chk(dec_ready_o === 1'b1, "ready after recovery");
      u_cond.resolve(1, 1'b1);
      chk(res_done_o === 1'b0, "resolve with nothing open");
    end
  endtask
  // Watchdog at 20000 cycles, over twice the 8192-cycle sweep plus a few hundred of traffic
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    stop_test;
  end
  initial begin
    {dec_valid_i, dec_kind_i, dec_pc_i, dec_len_i, dec_disp8_i, dec_disp32_i} = '0;
    {dec_tsel_i, btc_wr_i, btc_wr_addr_i, btc_wr_data_i} = '0;
    n_fail = 0;
    samples_checked = 0;
    sys_rst_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    n = 0;
    while (dec_ready_o !== 1'b1 && n < 9000) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk(dec_ready_o === 1'b1, "ready after sweep");
    t_jmp;
    t_btc;
    t_ras;
    t_spec;
    stop_test;
  end
endmodule // tb_top
